//--- verilog/trm_pkg.sv
package trm_pkg;
   localparam int NMOD  = 4;
   localparam int NLVDS = 8;
   localparam int NLINE = 2 * NMOD + NLVDS + 3;
   localparam int NECLK = 4;

   // Line index map of the routing matrix
   localparam int IDX_A    = 0;
   localparam int IDX_B    = NMOD;
   localparam int IDX_LVDS = 2 * NMOD;
   localparam int IDX_TTL  = 2 * NMOD + NLVDS;
   localparam int IDX_LAN  = IDX_TTL + 1;
   localparam int IDX_SW   = IDX_TTL + 2;

   // Byte offsets of the register map
   localparam logic [7:0] OFS_LINE = 8'h00;
   localparam logic [7:0] OFS_ECLK = 8'h80;
   localparam logic [7:0] OFS_SWTR = 8'hA0;
   localparam logic [7:0] OFS_STAT = 8'hA4;
   localparam logic [7:0] OFS_LVLS = 8'hA8;

   localparam logic [31:0] LINE_WMASK = 32'h000F_F73F;
   localparam logic [31:0] LINE_RST   = 32'h0000_0004;
   localparam logic [31:0] ECLK_WMASK = 32'h0000_007F;
   localparam logic [31:0] ECLK_RST   = 32'h0000_0000;

   // Source type codes
   localparam logic [2:0] SRC_TTL  = 3'h0;
   localparam logic [2:0] SRC_LVDS = 3'h1;
   localparam logic [2:0] SRC_A    = 3'h2;
   localparam logic [2:0] SRC_B    = 3'h3;
   localparam logic [2:0] SRC_LAN  = 3'h4;
   localparam logic [2:0] SRC_SW   = 3'h7;

   typedef struct packed {
      logic [11:0] rsv_hi;
      logic        ttl_termination_select;
      logic        ttl_threshold_select;
      logic        lvds_driven;
      logic        lvds_bias_enable;
      logic        out_inv;
      logic [2:0]  src_num;
      logic        rsv_b11;
      logic [2:0]  src_type;
      logic [1:0]  rsv_b7;
      logic [1:0]  eclk_sel;
      logic        falling;
      logic        level;
      logic        in_inv;
      logic        dir_out;
   } trm_line_cfg_t;

   typedef struct packed {
      logic [24:0] rsv;
      logic [2:0]  src_num;
      logic [2:0]  src_type;
      logic        enable;
   } trm_eclk_cfg_t;

   typedef struct packed {
      logic       level;
      logic       falling;
      logic       in_inv;
      logic       is_input;
      logic [1:0] eclk_sel;
   } trm_cond_t;
endpackage : trm_pkg

//--- verilog/trm_cond.sv
`timescale 1ns/1ps
module trm_cond
   import trm_pkg::*;
#(
   parameter bit SYNC = 1'b1
) (
   // Clock and reset
   input  wire logic                  clock_in,
   input  wire logic                  rst_in,
   input  wire logic                  ce_in,
   // Line and its setup
   input  wire logic                  raw_in,
   input  wire trm_cond_t             cfg_in,
   input  wire logic [NECLK-1:0]      rise_in,
   input  wire logic [NECLK-1:0]      fall_in,
   // Conditioned line
   output logic                       pre_out,
   output logic                       cond_out
);
   logic s1;
   logic s2;
   logic held;
   logic pol;
   logic hit;

   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         s1 <= 1'b0;
         s2 <= 1'b0;
      end else if (ce_in) begin
         s1 <= raw_in;
         s2 <= s1;
      end
   end

   // Pins pass two flops; software level is already on this clock
   assign pol = (SYNC ? s2 : raw_in) ^ cfg_in.in_inv;
   assign pre_out = cfg_in.is_input & pol;
   assign hit = cfg_in.falling ? fall_in[cfg_in.eclk_sel]
                               : rise_in[cfg_in.eclk_sel];

   always_ff @(posedge clock_in) begin
      if (rst_in)
         held <= 1'b0;
      else if (ce_in && hit)
         held <= pre_out;
   end

   assign cond_out = cfg_in.level ? pre_out : held;
endmodule : trm_cond

//--- verilog/trm_matrix.sv
`timescale 1ns/1ps
// Overview of operation
// - Every module, LVDS and TTL line is set as input or output.
// - Direction is seen from the routing logic; module-made triggers are inputs.
// - One input may feed any number of outputs at once.
// - Each input passes as a level or is latched on an edge clock.
// - Four independent edge clock selections exist.
// - Any input line can serve as an edge clock.
// - Each input may be inverted before routing.
// - Any input may be chosen as the source of an output.
// - Each output may be inverted before driving its line.
// - Every module position has lines A and B, both ways.
// - Eight LVDS trigger lines are handled.
// - TTL has one dedicated input and one dedicated output line.
// - Software bits pick TTL threshold and TTL termination.
// - Bias enable drives wired-OR bias always and ignores other LVDS bits.
// - Bias mode equals driven mode holding logic 0.
// - Driven mode drives 0 when idle and 1 when asserted.
// - Source type code: 0 TTL, 1 LVDS, 2 A, 3 B, 4 LAN, 7 SW.
// - Edge/level bit 0 edge, 1 level; falling bit 0 rise, 1 fall.
// - Source number picks the line; ignored for TTL, LAN and software.
module trm_matrix
   import trm_pkg::*;
(
   // Clock, reset and enable
   input  wire logic                   clock_in,
   input  wire logic                   rst_in,
   input  wire logic                   ce_in,
   // Avalon-MM slave
   input  wire logic [7:0]             avs_address_in,
   input  wire logic                   avs_read_in,
   input  wire logic                   avs_write_in,
   input  wire logic [31:0]            avs_writedata_in,
   input  wire logic [3:0]             avs_byteenable_in,
   output logic      [31:0]            avs_readdata_out,
   output logic                        avs_waitrequest_out,
   // Module trigger lines A
   input  wire logic [NMOD-1:0]        module_trigger_line_a_in,
   output logic      [NMOD-1:0]        module_trigger_line_a_out,
   output logic      [NMOD-1:0]        module_trigger_line_a_oe_out,
   // Module trigger lines B
   input  wire logic [NMOD-1:0]        module_trigger_line_b_in,
   output logic      [NMOD-1:0]        module_trigger_line_b_out,
   output logic      [NMOD-1:0]        module_trigger_line_b_oe_out,
   // LVDS trigger lines
   input  wire logic [NLVDS-1:0]       lvds_trigger_in,
   output logic      [NLVDS-1:0]       lvds_trigger_out,
   output logic      [NLVDS-1:0]       lvds_trigger_oe_out,
   // TTL and LAN triggers
   input  wire logic                   ttl_trigger_in,
   output logic                        ttl_trigger_out,
   output logic                        ttl_threshold_select_out,
   output logic                        ttl_termination_select_out,
   input  wire logic                   lan_trigger_in
);
   trm_line_cfg_t          line_cfg [NLINE];
   trm_eclk_cfg_t          eclk_cfg [NECLK];
   logic                   sw_level;
   logic [NLINE-1:0]       raw;
   logic [NLINE-1:0]       pre;
   logic [NLINE-1:0]       cond;
   logic [NLINE-1:0]       routed;
   logic [NECLK-1:0]       latch_edge_clock;
   logic [NECLK-1:0]       eclk_prev;
   logic [NECLK-1:0]       eclk_rise;
   logic [NECLK-1:0]       eclk_fall;
   logic                   acked;
   logic [31:0]            next_rdata;
   logic [31:0]            wmask;
   logic                   req;
   logic [5:0]             widx;

   // Source type and number to line index; reserved codes give none
   function automatic logic [5:0] src_index(input logic [2:0] typ,
                                            input logic [2:0] num);
      logic [5:0] r;
      r = 6'h3F;
      unique case (typ)
         SRC_TTL:  r = 6'(IDX_TTL);
         SRC_LVDS: r = 6'(IDX_LVDS) + {3'h0, num};
         SRC_A:    r = 6'(IDX_A) + {4'h0, num[1:0]};
         SRC_B:    r = 6'(IDX_B) + {4'h0, num[1:0]};
         SRC_LAN:  r = 6'(IDX_LAN);
         SRC_SW:   r = 6'(IDX_SW);
         default:  r = 6'h3F;
      endcase
      return r;
   endfunction : src_index

   function automatic logic pick(input logic [NLINE-1:0] v,
                                 input logic [5:0] i);
      logic r;
      r = 1'b0;
      if (i < 6'(NLINE))
         r = v[i[4:0]];
      return r;
   endfunction : pick

   assign raw = {sw_level, lan_trigger_in, ttl_trigger_in,
                 lvds_trigger_in, module_trigger_line_b_in,
                 module_trigger_line_a_in};

   // One conditioner per line; software line needs no synchroniser
   genvar g;
   generate
      for (g = 0; g < NLINE; g++) begin : g_line
         trm_cond #(
            .SYNC (g != IDX_SW)
         ) u_cond (
            .clock_in (clock_in),
            .rst_in   (rst_in),
            .ce_in    (ce_in),
            .raw_in   (raw[g]),
            .cfg_in   ('{level:    line_cfg[g].level,
                         falling:  line_cfg[g].falling,
                         in_inv:   line_cfg[g].in_inv,
                         is_input: ~line_cfg[g].dir_out,
                         eclk_sel: line_cfg[g].eclk_sel}),
            .rise_in  (eclk_rise),
            .fall_in  (eclk_fall),
            .pre_out  (pre[g]),
            .cond_out (cond[g])
         );
         // Output value of each line; any input may fan out freely
         assign routed[g] = pick(cond,
                                 src_index(line_cfg[g].src_type,
                                           line_cfg[g].src_num))
                            ^ line_cfg[g].out_inv;
      end
      for (g = 0; g < NECLK; g++) begin : g_eclk
         assign latch_edge_clock[g] = eclk_cfg[g].enable &
                                      pick(pre,
                                           src_index(eclk_cfg[g].src_type,
                                                     eclk_cfg[g].src_num));
         assign eclk_rise[g] = latch_edge_clock[g] & ~eclk_prev[g];
         assign eclk_fall[g] = ~latch_edge_clock[g] & eclk_prev[g];
      end
   endgenerate

   always_ff @(posedge clock_in) begin
      if (rst_in)
         eclk_prev <= '0;
      else if (ce_in)
         eclk_prev <= latch_edge_clock;
   end

   // Bus slave: one wait cycle, then the request completes
   assign req = avs_read_in | avs_write_in;
   assign widx = avs_address_in[7:2];
   always_comb begin
      wmask = '0;
      for (int b = 0; b < 4; b++)
         wmask[8*b +: 8] = {8{avs_byteenable_in[b]}};
   end

   always_comb begin
      next_rdata = 32'h0000_0000;
      if (avs_address_in < OFS_LINE + 8'(4 * NLINE))
         next_rdata = line_cfg[widx[4:0]];
      else if (avs_address_in >= OFS_ECLK &&
               avs_address_in < OFS_ECLK + 8'(4 * NECLK))
         next_rdata = eclk_cfg[widx[1:0]];
      else if (avs_address_in == OFS_SWTR)
         next_rdata = {31'h0, sw_level};
      else if (avs_address_in == OFS_STAT)
         next_rdata = 32'(cond);
      else if (avs_address_in == OFS_LVLS)
         next_rdata = 32'(routed);
   end

   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         avs_waitrequest_out <= 1'b1;
         avs_readdata_out    <= 32'h0000_0000;
         acked               <= 1'b0;
      end else if (ce_in) begin
         acked <= req & ~acked;
         avs_waitrequest_out <= ~(req & ~acked);
         if (req && !acked)
            avs_readdata_out <= next_rdata;
      end
   end

   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         for (int i = 0; i < NLINE; i++)
            line_cfg[i] <= LINE_RST;
      end else if (ce_in && avs_write_in && acked &&
                   avs_address_in < OFS_LINE + 8'(4 * NLINE)) begin
         line_cfg[widx[4:0]] <= (line_cfg[widx[4:0]] & ~(wmask & LINE_WMASK))
                              | (avs_writedata_in & wmask & LINE_WMASK);
      end
   end

   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         for (int i = 0; i < NECLK; i++)
            eclk_cfg[i] <= ECLK_RST;
      end else if (ce_in && avs_write_in && acked &&
                   avs_address_in >= OFS_ECLK &&
                   avs_address_in < OFS_ECLK + 8'(4 * NECLK)) begin
         eclk_cfg[widx[1:0]] <= (eclk_cfg[widx[1:0]] & ~(wmask & ECLK_WMASK))
                              | (avs_writedata_in & wmask & ECLK_WMASK);
      end
   end

   always_ff @(posedge clock_in) begin
      if (rst_in)
         sw_level <= 1'b0;
      else if (ce_in && avs_write_in && acked &&
               avs_address_in == OFS_SWTR && avs_byteenable_in[0])
         sw_level <= avs_writedata_in[0];
   end

   // Module lines drive only when set as outputs
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         module_trigger_line_a_out    <= '0;
         module_trigger_line_a_oe_out <= '0;
         module_trigger_line_b_out    <= '0;
         module_trigger_line_b_oe_out <= '0;
      end else if (ce_in) begin
         for (int i = 0; i < NMOD; i++) begin
            module_trigger_line_a_out[i]    <= routed[IDX_A + i];
            module_trigger_line_a_oe_out[i] <= line_cfg[IDX_A + i].dir_out;
            module_trigger_line_b_out[i]    <= routed[IDX_B + i];
            module_trigger_line_b_oe_out[i] <= line_cfg[IDX_B + i].dir_out;
         end
      end
   end

   // LVDS: bias, driven or wired-OR; the far devices stay wired-OR
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         lvds_trigger_out    <= '0;
         lvds_trigger_oe_out <= '0;
      end else if (ce_in) begin
         for (int i = 0; i < NLVDS; i++) begin
            if (line_cfg[IDX_LVDS + i].lvds_bias_enable) begin
               lvds_trigger_out[i]    <= 1'b0;
               lvds_trigger_oe_out[i] <= 1'b1;
            end else if (!line_cfg[IDX_LVDS + i].dir_out) begin
               lvds_trigger_out[i]    <= 1'b0;
               lvds_trigger_oe_out[i] <= 1'b0;
            end else if (line_cfg[IDX_LVDS + i].lvds_driven) begin
               lvds_trigger_out[i]    <= routed[IDX_LVDS + i];
               lvds_trigger_oe_out[i] <= 1'b1;
            end else begin
               lvds_trigger_out[i]    <= 1'b1;
               lvds_trigger_oe_out[i] <= routed[IDX_LVDS + i];
            end
         end
      end
   end

   // TTL: separate input and output pins, output low while unused
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         ttl_trigger_out            <= 1'b0;
         ttl_threshold_select_out   <= 1'b0;
         ttl_termination_select_out <= 1'b0;
      end else if (ce_in) begin
         ttl_trigger_out <= line_cfg[IDX_TTL].dir_out &
                            routed[IDX_TTL];
         ttl_threshold_select_out <=
            line_cfg[IDX_TTL].ttl_threshold_select;
         ttl_termination_select_out <=
            line_cfg[IDX_TTL].ttl_termination_select;
      end
   end
endmodule : trm_matrix

//--- tb/trm_asserts.sv
`timescale 1ns/1ps
module trm_asserts
   import trm_pkg::*;
(
   // Clock and bus
   input wire logic             clock_in,
   input wire logic             rst_in,
   input wire logic             ce_in,
   input wire logic [7:0]       avs_address_in,
   input wire logic             avs_read_in,
   input wire logic             avs_write_in,
   input wire logic [31:0]      avs_readdata_out,
   input wire logic             avs_waitrequest_out,
   // Pin side
   input wire logic [NMOD-1:0]  module_trigger_line_b_oe_out,
   input wire logic [NLVDS-1:0] lvds_trigger_oe_out,
   input wire logic             ttl_threshold_select_out,
   input wire logic             ttl_termination_select_out
);
   default clocking @(posedge clock_in); endclocking
   default disable iff (rst_in);
   logic       rd;
   logic       hit;
   logic [5:0] wa;
   assign wa  = avs_address_in[7:2];
   assign rd  = ce_in && !avs_waitrequest_out && avs_read_in;
   assign hit = ce_in && !avs_waitrequest_out && avs_write_in && wa == 6'h10;
   chk_bus_answer: assert property (
      ce_in && (avs_read_in || avs_write_in) && avs_waitrequest_out ##1 ce_in
      |-> !avs_waitrequest_out)
      else $error("request not answered after one cycle");
   chk_bus_pulse: assert property (
      ce_in && !avs_waitrequest_out |=> avs_waitrequest_out)
      else $error("waitrequest low for more than one cycle");
   chk_reset_idle: assert property (disable iff (1'b0)
      rst_in && ce_in |=> avs_waitrequest_out && avs_readdata_out == 32'h0
      && lvds_trigger_oe_out == 8'h0 && module_trigger_line_b_oe_out == 4'h0)
      else $error("outputs not idle after reset");
   chk_unmapped_zero: assert property (
      rd && (wa > 6'h2A || wa inside {[6'h13:6'h1F], [6'h24:6'h27]})
      |-> avs_readdata_out == 32'h0)
      else $error("unmapped read returned data");
   chk_line_reserved: assert property (
      rd && wa < 6'h13 |-> (avs_readdata_out & ~LINE_WMASK) == 32'h0)
      else $error("reserved line bits read back set");
   chk_clock_reserved: assert property (
      rd && wa inside {[6'h20:6'h23]}
      |-> (avs_readdata_out & ~ECLK_WMASK) == 32'h0)
      else $error("reserved edge clock bits read back set");
   chk_ttl_level: assert property (
      $changed(ttl_threshold_select_out) |-> $past(hit) || $past(hit, 2)
      || $past(rst_in) || $past(rst_in, 2))
      else $error("threshold select moved without a write");
   chk_ttl_load: assert property (
      $changed(ttl_termination_select_out) |-> $past(hit) || $past(hit, 2)
      || $past(rst_in) || $past(rst_in, 2))
      else $error("termination select moved without a write");
   cov_read: cover property (rd);
   cov_bias: cover property (|lvds_trigger_oe_out);
   cov_load: cover property ($rose(ttl_termination_select_out));
endmodule : trm_asserts

bind trm_matrix trm_asserts u_chk (.*);

//--- tb/trm_far_side.sv
`timescale 1ns/1ps
module trm_far_side
   import trm_pkg::*;
(
   // Far side drive
   input  wire logic [NMOD-1:0]  a_drv_in,
   input  wire logic [NMOD-1:0]  b_drv_in,
   input  wire logic [NLVDS-1:0] lvds_drv_in,
   // Carrier drive
   input  wire logic [NMOD-1:0]  a_out_in,
   input  wire logic [NMOD-1:0]  a_oe_in,
   input  wire logic [NMOD-1:0]  b_out_in,
   input  wire logic [NMOD-1:0]  b_oe_in,
   input  wire logic [NLVDS-1:0] lvds_out_in,
   input  wire logic [NLVDS-1:0] lvds_oe_in,
   // Resolved pins
   output logic      [NMOD-1:0]  a_pin_out,
   output logic      [NMOD-1:0]  b_pin_out,
   output logic      [NLVDS-1:0] lvds_pin_out
);
   // A module drives its line only while the carrier leaves it free
   assign a_pin_out = a_oe_in & a_out_in | ~a_oe_in & a_drv_in;
   assign b_pin_out = b_oe_in & b_out_in | ~b_oe_in & b_drv_in;
   // Others run wired-OR: bias holds low, any asserting party pulls high
   assign lvds_pin_out = lvds_drv_in | lvds_oe_in & lvds_out_in;
endmodule : trm_far_side

//--- tb/trm_matrix_bench.sv
`timescale 1ns/1ps
module trm_matrix_bench
   import trm_pkg::*;
();
   logic             clock_in, rst_in, rd, wr, wq, ttl, lan, t_out, thr, term;
   logic [7:0]       addr;
   logic [31:0]      wd, rdata, q;
   logic [NMOD-1:0]  a_drv, b_drv, a_pin, b_pin, a_out, a_oe, b_out, b_oe;
   logic [NLVDS-1:0] l_drv, l_pin, l_out, l_oe;
   int               fail_count, total_checks, cycles;
   logic [2:0]       typ [8] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7, 3'h5, 3'h6};
   logic [2:0]       num [8] = '{3'h5, 3'h3, 3'h2, 3'h3, 3'h0, 3'h5, 3'h0, 3'h0};
   logic [2:0]       stp [10] = '{3'h4, 3'h7, 3'h3, 3'h1, 3'h2,
                                  3'h6, 3'h5, 3'h7, 3'h3, 3'h0};
   logic [31:0]      lcfg [6] = '{32'h10701, 32'h30701, 32'h20701,
                                  32'h20701, 32'h00701, 32'h00701};
   // Software level, then expected enable and drive
   logic [2:0]       lexp [6] = '{3'h6, 3'h2, 3'h7, 3'h2, 3'h7, 3'h1};

   trm_matrix u_dut (
      .clock_in(clock_in), .rst_in(rst_in), .ce_in(1'b1),
      .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr),
      .avs_writedata_in(wd), .avs_byteenable_in(4'hF),
      .avs_readdata_out(rdata), .avs_waitrequest_out(wq),
      .module_trigger_line_a_in(a_pin), .module_trigger_line_a_out(a_out),
      .module_trigger_line_a_oe_out(a_oe), .module_trigger_line_b_in(b_pin),
      .module_trigger_line_b_out(b_out), .module_trigger_line_b_oe_out(b_oe),
      .lvds_trigger_in(l_pin), .lvds_trigger_out(l_out),
      .lvds_trigger_oe_out(l_oe), .ttl_trigger_in(ttl),
      .ttl_trigger_out(t_out), .ttl_threshold_select_out(thr),
      .ttl_termination_select_out(term), .lan_trigger_in(lan));
   trm_far_side u_far (
      .a_drv_in(a_drv), .b_drv_in(b_drv), .lvds_drv_in(l_drv),
      .a_out_in(a_out), .a_oe_in(a_oe), .b_out_in(b_out), .b_oe_in(b_oe),
      .lvds_out_in(l_out), .lvds_oe_in(l_oe), .a_pin_out(a_pin),
      .b_pin_out(b_pin), .lvds_pin_out(l_pin));

   initial begin
      clock_in = 1'b0;
      forever #4 clock_in = ~clock_in;
   end
   always @(posedge clock_in) begin
      cycles++;
      if (cycles == 30000) begin
         fail_count++;
         conclude();
      end
   end

   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : conclude
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : check
   task automatic tick(input int n);
      repeat (n) @(posedge clock_in);
      #1;
   endtask : tick
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge clock_in);
      addr <= a;
      wd   <= d;
      wr   <= w;
      rd   <= ~w;
      @(posedge clock_in);
      while (wq !== 1'b0)
         @(posedge clock_in);
      q = rdata;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask : bus
   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      check(q, e);
   endtask : rdchk
   task automatic src(input logic [2:0] ty, input logic v);
      if (ty > SRC_LAN)
         bus(1'b1, OFS_SWTR, 32'(v));
      @(posedge clock_in);
      ttl      <= v && ty == SRC_TTL;
      l_drv[3] <= v && ty == SRC_LVDS;
      a_drv[2] <= v && ty == SRC_A;
      b_drv[3] <= v && ty == SRC_B;
      lan      <= v && ty == SRC_LAN;
   endtask : src

   initial begin
      {rst_in, rd, wr, ttl, lan} = 5'h10;
      {a_drv, b_drv, l_drv, addr, wd} = '0;
      repeat (4) @(posedge clock_in);
      rst_in <= 1'b0;
      rdchk(OFS_LINE, LINE_RST);
      rdchk(OFS_ECLK, ECLK_RST);
      bus(1'b1, 8'h48, 32'hFFFF_FFFF);
      rdchk(8'h48, LINE_WMASK);
      bus(1'b1, 8'h48, LINE_RST);
      bus(1'b1, 8'h8C, 32'hFFFF_FFFF);
      rdchk(8'h8C, ECLK_WMASK);
      bus(1'b1, 8'h8C, ECLK_RST);
      bus(1'b1, 8'hFC, 32'hFFFF_FFFF);
      rdchk(8'hFC, 32'h0);
      $display("test registers done");
      bus(1'b1, 8'h10, 32'h0000_0201);
      bus(1'b1, 8'h14, 32'h0000_8201);
      tick(4);
      check(32'({b_oe[1:0], b_out[1:0]}), 32'hE);
      check(32'({a_oe, a_out}), 32'h0);
      @(posedge clock_in);
      a_drv[0] <= 1'b1;
      tick(2);
      check(32'(b_out[1:0]), 32'h2);
      tick(1);
      check(32'({b_oe[1:0], b_out[1:0]}), 32'hD);
      bus(1'b1, OFS_LINE, 32'h0000_0006);
      tick(4);
      check(32'(b_out[1:0]), 32'h2);
      $display("test fan-out done");
      for (int i = 0; i < 8; i++) begin
         bus(1'b1, 8'h10, {17'h0, num[i], 1'b0, typ[i], 8'h01});
         src(typ[i], 1'b1);
         tick(4);
         check(32'(b_out[0]), 32'(i < 6));
         src(typ[i], 1'b0);
         tick(4);
         check(32'(b_out[0]), 32'h0);
      end
      bus(1'b1, 8'h40, 32'h000C_0701);
      bus(1'b1, OFS_SWTR, 32'h1);
      tick(4);
      check(32'({t_out, thr, term}), 32'h7);
      bus(1'b1, 8'h40, 32'h0004_0004);
      tick(4);
      check(32'({thr, term}), 32'h2);
      $display("test sources done");
      for (int i = 0; i < 6; i++) begin
         bus(1'b1, OFS_SWTR, 32'(lexp[i][2]));
         bus(1'b1, 8'h24, lcfg[i]);
         tick(4);
         check(32'({l_oe[1], l_out[1]}), 32'(lexp[i][1:0]));
      end
      $display("test lvds done");
      bus(1'b1, 8'h10, 32'h0000_1201);
      for (int k = 0; k < 4; k++) begin
         bus(1'b1, OFS_ECLK + 8'(4 * k), 32'h9);
         bus(1'b1, 8'h04, 32'(16 * k));
         for (int i = 0; i < 10; i++) begin
            if (i == 5)
               bus(1'b1, 8'h04, 32'(16 * k + 8));
            @(posedge clock_in);
            a_drv[1] <= stp[i][2];
            lan      <= stp[i][1];
            tick(8);
            check(32'(b_out[0]), 32'(stp[i][0]));
         end
      end
      $display("test edge latch done");
      conclude();
   end
endmodule : trm_matrix_bench
